//--- inc/dcc_pkg.sv
// Constants, field layout and carrier types of the DMA channel event block
// Contract
// [RULE1] Any channel register may be written while disabled; status shows channel enabled.
// [RULE2] Software leaves source, destination and count alone while channel is active.
// [RULE3] Software stops a channel by clearing its global enable, then polls active.
// [RULE4] Global flags hold pending per channel; interrupt only where global enable set.
// [RULE5] With count-zero enable, every count-to-zero sets channel interrupt pending.
// [RULE6] With disable enable, every active one-to-zero change sets interrupt pending.
// [RULE7] Disable enable also enables timeout flag; timeout leaves channel active.
// [RULE8] Count-zero, done, bus-error and timeout flags clear by writing one.
// [RULE9] No reload, disable enable only: interrupt on completion, bus error, timeout.
// [RULE10] Chaining with count-zero enable: interrupt at each reload; errors still reported.
// [RULE11] Chaining without count-zero enable: only final no-reload completion interrupts.
// [RULE12] Each channel has a 10-bit timeout counter stepped at a prescaled rate.
// [RULE13] Prescale 0 disables; 1,2,3 give 2^8, 2^16, 2^24 clocks times period.
// [RULE14] Without wait-for-request, counting starts once period is nonzero.
// [RULE15] With wait-for-request, counting starts at the first peripheral request.
// [RULE16] Counter resets on a request and whenever the channel is disabled.
// [RULE17] On expiry set timeout flag and keep the channel enabled.
// [RULE18] Memory-to-memory channel requests as if its request were always asserted.
// [RULE19] Software gives memory-to-memory channels lower priority.
// [RULE20] Software leaves enable bits of unimplemented channels unchanged.
// [RULE21] Global flags are read-only, cleared only through channel status causes.
// [RULE22] Channel groups start at 0x100,0x120,0x140,0x160,0x180,0x200,0x220,0x240.
// [RULE23] Count-to-zero is a finished burst that leaves the byte count at zero.
// [RULE24] Count-to-zero reloads with reload on, else disables and clears active.
// [RULE25] Each global flag mirrors its channel's enabled-and-set cause OR.
package dcc_pkg;
	localparam int NUM_CH = 8;
	localparam int ADDR_W = 12;
	// Global register offsets
	localparam logic [11:0] GLOBAL_IRQ_ENABLE_OFS = 12'h000;
	localparam logic [11:0] GLOBAL_IRQ_FLAGS_OFS = 12'h004;
	// Channel group bases
	localparam logic [7:0][11:0] CH_BASE = {12'h240, 12'h220, 12'h200, 12'h180,
		12'h160, 12'h140, 12'h120, 12'h100};
	// Word index inside a channel group
	localparam logic [2:0] CH_CONTROL_IDX = 3'h0;
	localparam logic [2:0] CH_STATE_IDX = 3'h1;
	localparam logic [2:0] CH_SOURCE_IDX = 3'h2;
	localparam logic [2:0] CH_DEST_IDX = 3'h3;
	localparam logic [2:0] CH_COUNT_IDX = 3'h4;
	localparam logic [2:0] CH_SOURCE_RLD_IDX = 3'h5;
	localparam logic [2:0] CH_DEST_RLD_IDX = 3'h6;
	localparam logic [2:0] CH_COUNT_RLD_IDX = 3'h7;
	// Control field positions
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_RELOAD_BIT = 1;
	localparam int CTL_WAIT_REQ_BIT = 2;
	localparam int CTL_MEM2MEM_BIT = 3;
	localparam int CTL_PERIOD_LSB = 4;
	localparam int CTL_PRESCALE_LSB = 14;
	localparam int CTL_DISABLE_IRQ_ENABLE_BIT = 30;
	localparam int CTL_COUNT_ZERO_IRQ_ENABLE_BIT = 31;
	// Control bits that store as written; enable is the live active bit
	localparam logic [31:0] CTL_STORE_MASK = 32'hdf77fffe;
	// Status field positions
	localparam int ST_ACTIVE_BIT = 0;
	localparam int ST_IPEND_BIT = 1;
	localparam int ST_CTZ_BIT = 2;
	localparam int ST_DONE_BIT = 3;
	localparam int ST_BUS_ERR_BIT = 4;
	localparam int ST_STOP_BIT = 5;
	localparam int ST_TIMEOUT_BIT = 6;
	// Reset values and prescale widths
	localparam logic [31:0] REG_RESET = 32'h00000000;
	localparam int PRE_8 = 8;
	localparam int PRE_16 = 16;
	localparam int PRE_24 = 24;
	// Register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
	} dcc_bus_req_type;
	// Per-channel cause flags
	typedef struct packed {
		logic timeout;
		logic stop;
		logic bus_err;
		logic done;
		logic ctz;
	} dcc_flags_type;
endpackage

//--- logic/dcc_channel_events.sv
// Event, chaining and timeout logic for eight DMA channels with register port
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module dcc_channel_events
	import dcc_pkg::*;
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Register port
	input wire dcc_bus_req_type bus_in,
	output logic [31:0] rdata_out,
	// Datapath events, one bit per channel, plus a shared burst byte count
	input wire logic [NUM_CH-1:0] request_in,
	input wire logic [NUM_CH-1:0] burst_done_in,
	input wire logic [5:0] burst_bytes_in,
	input wire logic [NUM_CH-1:0] bus_error_in,
	// Channel state toward datapath and core
	output logic [NUM_CH-1:0] channel_active_out,
	output logic [NUM_CH-1:0] channel_request_out,
	output logic [NUM_CH-1:0] channel_irq_out
);
	typedef struct packed {
		logic [NUM_CH-1:0][31:0] control;
		logic [NUM_CH-1:0] active;
		dcc_flags_type [NUM_CH-1:0] flags;
		logic [NUM_CH-1:0][31:0] source;
		logic [NUM_CH-1:0][31:0] dest;
		logic [NUM_CH-1:0][31:0] count;
		logic [NUM_CH-1:0][31:0] source_rld;
		logic [NUM_CH-1:0][31:0] dest_rld;
		logic [NUM_CH-1:0][31:0] count_rld;
		logic [31:0] global_irq_enable;
		logic [NUM_CH-1:0] tmr_started;
		logic [NUM_CH-1:0][9:0] tmr_count;
		logic [NUM_CH-1:0][15:0] tmr_sub;
		logic [7:0] prediv;
		logic [31:0] rdata;
	} dcc_state_type;

	dcc_state_type state_reg;
	dcc_state_type state_next;
	logic [NUM_CH-1:0] ipend;

	// Channel group hit: returns {hit, channel index}
	function automatic logic [3:0] chan_decode(input logic [ADDR_W-1:0] addr);
		logic [3:0] res;
		res = 4'h0;
		for (int c = 0; c < NUM_CH; c++) begin
			if (addr[ADDR_W-1:5] == CH_BASE[c][ADDR_W-1:5]) begin // [RULE22]
				res = {1'b1, 3'(c)};
			end
		end
		return res;
	endfunction

	// Interrupt pending from enabled causes
	function automatic logic pend_of(input logic [31:0] ctl, input dcc_flags_type f);
		logic dis_causes;
		dis_causes = f.done | f.bus_err | f.stop | f.timeout;
		return (ctl[CTL_COUNT_ZERO_IRQ_ENABLE_BIT] & f.ctz) | (ctl[CTL_DISABLE_IRQ_ENABLE_BIT] & dis_causes);
	endfunction

	// Status word as software sees it
	function automatic logic [31:0] status_word(input logic act, input logic pend,
		input dcc_flags_type f);
		logic [31:0] w;
		w = REG_RESET;
		w[ST_ACTIVE_BIT] = act;
		w[ST_IPEND_BIT] = pend;
		w[ST_CTZ_BIT] = f.ctz;
		w[ST_DONE_BIT] = f.done;
		w[ST_BUS_ERR_BIT] = f.bus_err;
		w[ST_STOP_BIT] = f.stop;
		w[ST_TIMEOUT_BIT] = f.timeout;
		return w;
	endfunction

	// Pending per channel, mirrored into the read-only global flags
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			ipend[c] = pend_of(state_reg.control[c], state_reg.flags[c]); // [RULE25] [RULE9]
		end
	end

	// Next-state logic: register writes, then hardware events per channel
	always_comb begin
		logic [3:0] hit;
		logic [2:0] idx;
		logic wr_ch;
		logic [31:0] wd;
		logic tick;
		logic [31:0] left;
		logic [31:0] clr_mask;
		logic stopping;
		logic ctz;
		logic [9:0] per;
		logic [1:0] pre;
		dcc_flags_type setf;
		dcc_flags_type clrf;
		hit = chan_decode(bus_in.addr);
		idx = bus_in.addr[4:2];
		wd = bus_in.wdata;
		tick = 1'b0;
		left = REG_RESET;
		clr_mask = REG_RESET;
		stopping = 1'b0;
		ctz = 1'b0;
		per = 10'h000;
		pre = 2'h0;
		setf = '0;
		clrf = '0;
		wr_ch = 1'b0;
		state_next = state_reg;
		state_next.prediv = state_reg.prediv + 8'h01;

		// Global enable; a bit going from one to zero stops that channel
		if (bus_in.wr && bus_in.addr == GLOBAL_IRQ_ENABLE_OFS) begin
			clr_mask = state_reg.global_irq_enable & ~wd; // [RULE3]
			state_next.global_irq_enable = wd;
		end

		for (int c = 0; c < NUM_CH; c++) begin
			wr_ch = bus_in.wr && hit[3] && (hit[2:0] == 3'(c));
			setf = '0;
			clrf = '0;
			// Register writes; every register is open while the channel is idle
			if (wr_ch) begin // [RULE1]
				unique case (idx)
					CH_CONTROL_IDX: begin
						state_next.control[c] = wd & CTL_STORE_MASK;
						state_next.active[c] = wd[CTL_ENABLE_BIT];
						state_next.tmr_started[c] = 1'b0;
						// A software disable is still a one-to-zero change of active
						if (state_reg.active[c] && !wd[CTL_ENABLE_BIT]) begin
							setf.stop = 1'b1; // [RULE6]
						end
					end
					CH_STATE_IDX: begin
						clrf.ctz = wd[ST_CTZ_BIT]; // [RULE8]
						clrf.done = wd[ST_DONE_BIT];
						clrf.bus_err = wd[ST_BUS_ERR_BIT];
						clrf.stop = wd[ST_STOP_BIT];
						clrf.timeout = wd[ST_TIMEOUT_BIT];
					end
					CH_SOURCE_IDX: state_next.source[c] = wd;
					CH_DEST_IDX: state_next.dest[c] = wd;
					CH_COUNT_IDX: state_next.count[c] = wd;
					CH_SOURCE_RLD_IDX: state_next.source_rld[c] = wd;
					CH_DEST_RLD_IDX: state_next.dest_rld[c] = wd;
					CH_COUNT_RLD_IDX: state_next.count_rld[c] = wd;
				endcase
			end

			// Burst completion; count saturates so a short last burst ends at zero
			if (state_reg.active[c] && burst_done_in[c]) begin
				left = (state_reg.count[c] > 32'(burst_bytes_in)) ?
					state_reg.count[c] - 32'(burst_bytes_in) : REG_RESET;
				state_next.count[c] = left;
				ctz = (left == REG_RESET); // [RULE23]
				if (ctz) begin
					if (state_reg.control[c][CTL_RELOAD_BIT]) begin
						setf.ctz = 1'b1; // [RULE5] [RULE10]
						state_next.source[c] = state_reg.source_rld[c]; // [RULE24]
						state_next.dest[c] = state_reg.dest_rld[c];
						state_next.count[c] = state_reg.count_rld[c];
					end else begin
						setf.ctz = 1'b1; // [RULE11]
						setf.done = 1'b1;
						state_next.active[c] = 1'b0; // [RULE24]
					end
				end
			end

			// Bus error ends the transfer
			if (state_reg.active[c] && bus_error_in[c]) begin
				setf.bus_err = 1'b1;
				state_next.active[c] = 1'b0;
			end

			// Software stop through the global enable
			stopping = state_reg.active[c] && clr_mask[c];
			if (stopping) begin
				setf.stop = 1'b1; // [RULE6]
				state_next.active[c] = 1'b0;
			end

			// Timeout counter
			per = state_reg.control[c][CTL_PERIOD_LSB +: 10];
			pre = state_reg.control[c][CTL_PRESCALE_LSB +: 2];
			unique case (pre)
				2'h0: tick = 1'b0; // [RULE13]
				2'h1: tick = (state_reg.prediv == 8'hff);
				2'h2: tick = (state_reg.prediv == 8'hff) && (state_reg.tmr_sub[c][7:0] == 8'hff);
				2'h3: tick = (state_reg.prediv == 8'hff) && (state_reg.tmr_sub[c] == 16'hffff);
			endcase
			if (!state_reg.active[c] || request_in[c]) begin
				// Reset on request or while disabled
				state_next.tmr_count[c] = 10'h000; // [RULE16]
				state_next.tmr_sub[c] = 16'h0000;
				if (request_in[c] && state_reg.active[c]) begin
					state_next.tmr_started[c] = 1'b1; // [RULE15]
				end
			end else if (!state_reg.control[c][CTL_WAIT_REQ_BIT] && per != 10'h000) begin
				state_next.tmr_started[c] = 1'b1; // [RULE14]
			end
			if (state_reg.active[c] && !request_in[c] && state_reg.tmr_started[c] &&
				pre != 2'h0 && per != 10'h000) begin
				if (state_reg.prediv == 8'hff) begin
					state_next.tmr_sub[c] = state_reg.tmr_sub[c] + 16'h0001;
				end
				if (tick) begin // [RULE12]
					state_next.tmr_sub[c] = 16'h0000;
					if (state_reg.tmr_count[c] + 10'h001 == per) begin
						setf.timeout = 1'b1; // [RULE17] [RULE7]
						state_next.tmr_count[c] = 10'h000;
					end else begin
						state_next.tmr_count[c] = state_reg.tmr_count[c] + 10'h001;
					end
				end
			end

			// Flag update: a cause arriving with its own clear is kept
			state_next.flags[c] = (state_reg.flags[c] & ~clrf) | setf; // [RULE8]
		end

		// Read data stands in the cycle after the strobe only
		state_next.rdata = REG_RESET;
		if (bus_in.rd) begin
			if (bus_in.addr == GLOBAL_IRQ_ENABLE_OFS) begin
				state_next.rdata = state_reg.global_irq_enable;
			end else if (bus_in.addr == GLOBAL_IRQ_FLAGS_OFS) begin
				state_next.rdata = 32'(ipend); // [RULE21]
			end else if (hit[3]) begin
				unique case (idx)
					CH_CONTROL_IDX: state_next.rdata = state_reg.control[hit[2:0]] |
						(32'(state_reg.active[hit[2:0]]) << CTL_ENABLE_BIT);
					CH_STATE_IDX: state_next.rdata = status_word(state_reg.active[hit[2:0]],
						ipend[hit[2:0]], state_reg.flags[hit[2:0]]); // [RULE1]
					CH_SOURCE_IDX: state_next.rdata = state_reg.source[hit[2:0]];
					CH_DEST_IDX: state_next.rdata = state_reg.dest[hit[2:0]];
					CH_COUNT_IDX: state_next.rdata = state_reg.count[hit[2:0]];
					CH_SOURCE_RLD_IDX: state_next.rdata = state_reg.source_rld[hit[2:0]];
					CH_DEST_RLD_IDX: state_next.rdata = state_reg.dest_rld[hit[2:0]];
					CH_COUNT_RLD_IDX: state_next.rdata = state_reg.count_rld[hit[2:0]];
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs; memory-to-memory channels ask for the bus on every cycle while active
	assign rdata_out = state_reg.rdata;
	assign channel_active_out = state_reg.active;
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			channel_request_out[c] = state_reg.active[c] &&
				(state_reg.control[c][CTL_MEM2MEM_BIT] || request_in[c]); // [RULE18]
		end
	end
	assign channel_irq_out = ipend & state_reg.global_irq_enable[NUM_CH-1:0]; // [RULE4]
endmodule // dcc_channel_events

//--- dv/dcc_far_model.sv
// Far-side model: peripheral request lines and burst completions
`timescale 1ns/1ps
module dcc_far_model
	import dcc_pkg::*;
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Bench commands
	input wire logic go_in,
	input wire logic err_in,
	input wire logic [5:0] bytes_in,
	input wire logic [3:0] lag_in,
	input wire logic [NUM_CH-1:0] line_in,
	// Channel side
	input wire logic [NUM_CH-1:0] chan_req_in,
	output logic [NUM_CH-1:0] request_out,
	output logic [NUM_CH-1:0] done_out,
	output logic [NUM_CH-1:0] error_out,
	output logic [5:0] bytes_out,
	output logic busy_out
);
	logic [3:0] wait_reg;
	// Request lines follow the bench; the byte count is junk away from a completion
	assign request_out = line_in;
	assign bytes_out = done_out[0] ? bytes_in : ~bytes_in;
	// One burst at a time on channel 0, counted down only while the channel asks for the bus
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			busy_out <= 1'b0;
			wait_reg <= 4'h0;
			done_out <= '0;
			error_out <= '0;
		end else begin
			done_out <= '0;
			error_out <= '0;
			if (go_in && !busy_out) begin
				busy_out <= 1'b1;
				wait_reg <= lag_in;
			end else if (busy_out && chan_req_in[0]) begin
				if (wait_reg != 4'h0) begin
					wait_reg <= wait_reg - 4'h1;
				end else begin
					busy_out <= 1'b0;
					done_out[0] <= !err_in;
					error_out[0] <= err_in;
				end
			end
		end
	end
endmodule // dcc_far_model

//--- dv/dcc_checker.sv
// Port assertions for the DMA channel event block
`timescale 1ns/1ps
module dcc_checker
	import dcc_pkg::*;
(
	// Watched ports
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire dcc_bus_req_type bus_in,
	input wire logic [31:0] rdata_out,
	input wire logic [NUM_CH-1:0] request_in,
	input wire logic [NUM_CH-1:0] burst_done_in,
	input wire logic [5:0] burst_bytes_in,
	input wire logic [NUM_CH-1:0] bus_error_in,
	input wire logic [NUM_CH-1:0] channel_active_out,
	input wire logic [NUM_CH-1:0] channel_request_out,
	input wire logic [NUM_CH-1:0] channel_irq_out
);
	logic [NUM_CH-1:0] en_reg;
	logic gwr;
	logic start0;
	// Writes that may start or stop channel 0
	assign gwr = bus_in.wr && bus_in.addr == GLOBAL_IRQ_ENABLE_OFS;
	assign start0 = bus_in.wr && bus_in.addr == CH_BASE[0] && bus_in.wdata[CTL_ENABLE_BIT];
	// Shadow of the global enables, since they are not visible at the ports
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			en_reg <= '0;
		end else if (gwr) begin
			en_reg <= bus_in.wdata[NUM_CH-1:0];
		end
	end
	default clocking dcc_cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	a_req_needs_active: assert property ((channel_request_out & ~channel_active_out) == '0)
		else $error("request on idle channel");
	a_req_follows_line: assert property ((channel_active_out & request_in & ~channel_request_out) == '0)
		else $error("request line not passed on");
	a_irq_needs_enable: assert property ((channel_irq_out & ~en_reg) == '0)
		else $error("irq without global enable");
	a_error_stops: assert property (bus_error_in[0] && channel_active_out[0] |=> !channel_active_out[0])
		else $error("bus error left channel on");
	a_active_holds: assert property (channel_active_out[0] && !bus_error_in[0] && !burst_done_in[0]
		&& !bus_in.wr |=> channel_active_out[0])
		else $error("channel dropped without cause");
	a_start_by_write: assert property ($rose(channel_active_out[0]) |-> $past(start0))
		else $error("channel started without write");
	a_stop_by_global: assert property (gwr && !bus_in.wdata[0] && en_reg[0] && channel_active_out[0]
		|=> !channel_active_out[0])
		else $error("global clear did not stop");
	a_irq_clear_write: assert property ($fell(channel_irq_out[0]) |-> $past(bus_in.wr))
		else $error("irq fell without a write");
	a_rdata_idle: assert property (!$past(bus_in.rd) |-> rdata_out == '0)
		else $error("read data outside its cycle");
endmodule // dcc_checker
bind dcc_channel_events dcc_checker u_chk (.clock_in, .rst_n_in, .bus_in, .rdata_out, .request_in,
	.burst_done_in, .burst_bytes_in, .bus_error_in, .channel_active_out, .channel_request_out,
	.channel_irq_out);

//--- dv/tb.sv
// Self-checking bench for the DMA channel event block
`timescale 1ns/1ps
module tb;
	import dcc_pkg::*;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} dcc_row_type;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	dcc_bus_req_type bus_in = '0;
	logic [31:0] rdata_out;
	logic [NUM_CH-1:0] request_in, burst_done_in, bus_error_in, line = 8'h00;
	logic [NUM_CH-1:0] channel_active_out, channel_request_out, channel_irq_out;
	logic [5:0] burst_bytes_in, nb = 6'h00;
	logic [3:0] lag = 4'h0;
	logic go = 1'b0, err = 1'b0, busy;
	int n_errors = 0, n_checks = 0, cyc = 0;
	// Map rows: all written first, then all read, so aliased words show up
	dcc_row_type rows [11] = '{'{12'h000, 32'hff, 32'hff}, '{12'h004, 32'hff, 32'h0},
		'{12'h108, 32'h11, 32'h11}, '{12'h128, 32'h22, 32'h22}, '{12'h148, 32'h33, 32'h33},
		'{12'h168, 32'h44, 32'h44}, '{12'h188, 32'h55, 32'h55}, '{12'h208, 32'h66, 32'h66},
		'{12'h228, 32'h77, 32'h77}, '{12'h248, 32'h88, 32'h88}, '{12'h1a8, 32'h99, 32'h0}};
	always #4 clock_in = ~clock_in;
	dcc_channel_events DUT (.clock_in, .rst_n_in, .bus_in, .rdata_out, .request_in, .burst_done_in,
		.burst_bytes_in, .bus_error_in, .channel_active_out, .channel_request_out, .channel_irq_out);
	dcc_far_model u_far (.clock_in, .rst_n_in, .go_in(go), .err_in(err), .bytes_in(nb), .lag_in(lag),
		.line_in(line), .chan_req_in(channel_request_out), .request_out(request_in),
		.done_out(burst_done_in), .error_out(bus_error_in), .bytes_out(burst_bytes_in), .busy_out(busy));
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus_in.wr <= 1'b1;
		bus_in.addr <= a;
		bus_in.wdata <= d;
		@(posedge clock_in);
		bus_in.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
		bus_in.rd <= 1'b1;
		bus_in.addr <= a;
		@(posedge clock_in);
		bus_in.rd <= 1'b0;
		#1 chk(what, e, rdata_out);
	endtask
	// One burst on channel 0 with its request line held until the far side is done
	task automatic burst(input logic [5:0] n, input logic e, input logic [3:0] l);
		nb <= n;
		err <= e;
		lag <= l;
		line <= 8'h01;
		go <= 1'b1;
		@(posedge clock_in);
		go <= 1'b0;
		#1;
		for (int i = 0; i < 40 && busy === 1'b1; i++) begin
			@(posedge clock_in);
			#1;
		end
		line <= 8'h00;
		@(posedge clock_in);
		#1;
	endtask
	// Hang guard: the whole run needs about 2800 cycles
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (12) @(posedge clock_in);
		rst_n_in <= 1'b1;
		@(posedge clock_in);
		#1;
		foreach (rows[i]) wr(rows[i].a, rows[i].d);
		foreach (rows[i]) rd(rows[i].a, rows[i].e, $sformatf("word %h", rows[i].a));
		$display("test map done");
		// Reset in mid-run must clear what the table left
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		rst_n_in <= 1'b1;
		@(posedge clock_in);
		#1;
		rd(12'h000, 32'h0, "enable reset");
		rd(12'h108, 32'h0, "source reset");
		$display("test reset done");
		// Chaining with count-zero enable, then a bus error in mid-chain
		wr(12'h000, 32'h03);
		wr(12'h110, 32'h8);
		wr(12'h11c, 32'h8);
		wr(12'h100, 32'hc0000003);
		burst(6'h08, 1'b0, 4'h3);
		chk("active reload", 32'h1, 32'(channel_active_out));
		chk("irq reload", 32'h1, 32'(channel_irq_out));
		rd(12'h104, 32'h7, "status ctz");
		rd(12'h110, 32'h8, "count reload");
		wr(12'h104, 32'h4);
		chk("irq clear", 32'h0, 32'(channel_irq_out));
		burst(6'h01, 1'b1, 4'h0);
		chk("active error", 32'h0, 32'(channel_active_out));
		rd(12'h004, 32'h1, "flags error");
		rd(12'h104, 32'h12, "status error");
		wr(12'h104, 32'h10);
		rd(12'h004, 32'h0, "flags clear");
		$display("test chain done");
		// Without count-zero enable only the last, unreloaded buffer interrupts
		wr(12'h110, 32'h4);
		wr(12'h100, 32'h40000003);
		burst(6'h04, 1'b0, 4'h0);
		chk("irq quiet", 32'h0, 32'(channel_irq_out));
		wr(12'h100, 32'h40000001);
		burst(6'h08, 1'b0, 4'h2);
		chk("irq final", 32'h1, 32'(channel_irq_out));
		rd(12'h104, 32'he, "status done");
		wr(12'h104, 32'hc);
		wr(12'h120, 32'h9);
		chk("mem request", 32'h2, 32'(channel_request_out));
		// Stopping through the control word counts as a disable, too
		wr(12'h120, 32'h40000000);
		rd(12'h124, 32'h22, "status soft stop");
		wr(12'h124, 32'h20);
		$display("test final done");
		// Timeout held off by the request line, then fires with ch0 still running
		line <= 8'h01;
		wr(12'h100, 32'h40004021);
		repeat (1200) @(posedge clock_in);
		#1 chk("irq held", 32'h0, 32'(channel_irq_out));
		line <= 8'h00;
		for (int i = 0; i < 700 && channel_irq_out[0] !== 1'b1; i++) begin
			@(posedge clock_in);
			#1;
		end
		chk("active timeout", 32'h1, 32'(channel_active_out));
		rd(12'h104, 32'h43, "status timeout");
		wr(12'h000, 32'h0);
		chk("active stop", 32'h0, 32'(channel_active_out));
		// Wait-for-request: no count until the first request, then expiry
		wr(12'h104, 32'h60);
		wr(12'h100, 32'h40004025);
		repeat (600) @(posedge clock_in);
		#1 rd(12'h004, 32'h0, "flags wait idle");
		line <= 8'h01;
		@(posedge clock_in);
		line <= 8'h00;
		repeat (600) @(posedge clock_in);
		#1 rd(12'h104, 32'h43, "status wait timeout");
		$display("test timeout done");
		report_and_stop();
	end
endmodule // tb
